// ---- hdl/txfdw_device.sv ----
`timescale 1ns/1ps
// How it works
// - Select high steers writes into transmit FIFO.
// - Select sampled like address, same write timing.
// - Sixteen-bit mode ignores upper data lines.
// - FIFO words keep only the word offset bits; register writes keep the full address.
// - Cycle spans both strobes low, any order.
// - Host holds strobes low 32, high 13, cycle 165.
// - Configuration latched on reset release, held around.
// - Strobes return high between consecutive writes.
module txfdw_device #(
	parameter int unsigned DEPTH = txfdw_pkg::FIFO_DEPTH
) (
	input  wire logic                                          clk,
	input  wire logic                                          reset,
	txfdw_if.device                                            port,
	input  wire logic                                          bus_16bit,
	output logic                                               fifo_valid,
	input  wire logic                                          fifo_ready,
	output logic [txfdw_pkg::DATA_W-1:0]                       fifo_data,
	output logic [txfdw_pkg::OFS_HI-txfdw_pkg::OFS_LO:0]       fifo_offset,
	output logic                                               reg_write,
	output logic [txfdw_pkg::ADDR_W-1:0]                       reg_addr,
	output logic [txfdw_pkg::DATA_W-1:0]                       reg_data,
	output logic [txfdw_pkg::CFG_W-1:0]                        cfg_latched,
	output logic                                               overflow
);
	localparam int unsigned OW = txfdw_pkg::OFS_HI - txfdw_pkg::OFS_LO + 1;
	localparam int unsigned FW = txfdw_pkg::DATA_W + OW;

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	// Every pin is asynchronous to clk, so each crosses two flops before use.
	localparam int unsigned SW = 4 + txfdw_pkg::ADDR_W + txfdw_pkg::DATA_W + txfdw_pkg::CFG_W;
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic [SW-1:0] next_sync1;

	always_comb
	begin
		next_sync1 = {port.select_strobe_n, port.write_strobe_n, port.hard_reset_n,
			port.fifo_sel, port.addr, port.data, port.cfg};
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sync1 <= '1;
			sync2 <= '1;
		end
		else
		begin
			sync1 <= next_sync1;
			sync2 <= sync1;
		end
	end

	logic                          cs_n_s;
	logic                          wr_n_s;
	logic                          rst_n_s;
	logic                          sel_s;
	logic [txfdw_pkg::ADDR_W-1:0]  addr_s;
	logic [txfdw_pkg::DATA_W-1:0]  data_s;
	logic [txfdw_pkg::CFG_W-1:0]   cfg_s;
	assign {cfg_s} = sync2[txfdw_pkg::CFG_W-1:0];
	assign data_s  = sync2[txfdw_pkg::CFG_W +: txfdw_pkg::DATA_W];
	assign addr_s  = sync2[txfdw_pkg::CFG_W + txfdw_pkg::DATA_W +: txfdw_pkg::ADDR_W];
	assign sel_s   = sync2[SW-4];
	assign rst_n_s = sync2[SW-3];
	assign wr_n_s  = sync2[SW-2];
	assign cs_n_s  = sync2[SW-1];

	// ==========================================================
	// Write cycle framing and steering
	// ==========================================================
	// The write completes on the trailing edge, where data setup is guaranteed.
	logic                         active;
	logic                         in_cycle;
	logic                         cycle_end;
	logic [txfdw_pkg::DATA_W-1:0] wdata;
	logic                         push_ready;
	logic                         next_active;
	logic                         next_reg_write;
	logic [txfdw_pkg::ADDR_W-1:0] next_reg_addr;
	logic [txfdw_pkg::DATA_W-1:0] next_reg_data;
	logic                         next_overflow;

	always_comb
	begin
		in_cycle  = !cs_n_s && !wr_n_s;
		cycle_end = active && !in_cycle;
		wdata     = data_s;
		if (bus_16bit)
			wdata = {{txfdw_pkg::HALF_W{1'b0}}, data_s[txfdw_pkg::HALF_W-1:0]};
		next_active    = in_cycle && rst_n_s;
		next_reg_write = cycle_end && !sel_s && rst_n_s;
		next_reg_addr  = addr_s;
		next_reg_data  = wdata;
		next_overflow  = overflow || (cycle_end && sel_s && rst_n_s && !push_ready);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			active    <= 1'b0;
			reg_write <= 1'b0;
			reg_addr  <= '0;
			reg_data  <= '0;
			overflow  <= 1'b0;
		end
		else
		begin
			active    <= next_active;
			reg_write <= next_reg_write;
			reg_addr  <= next_reg_addr;
			reg_data  <= next_reg_data;
			overflow  <= next_overflow;
		end
	end

	// ==========================================================
	// Configuration capture
	// ==========================================================
	// The edge detector resets high, so the synchroniser's all-ones reset
	// value is never mistaken for a release of the reset pin.
	logic                         rst_prev;
	logic                         next_rst_prev;
	logic [txfdw_pkg::CFG_W-1:0]  next_cfg;

	always_comb
	begin
		next_rst_prev = rst_n_s;
		next_cfg      = cfg_latched;
		if (rst_n_s && !rst_prev)
			next_cfg = cfg_s;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rst_prev    <= 1'b1;
			cfg_latched <= '0;
		end
		else
		begin
			rst_prev    <= next_rst_prev;
			cfg_latched <= next_cfg;
		end
	end

	// ==========================================================
	// Transmit data FIFO
	// ==========================================================
	// A full FIFO drops the word and flags overflow; the pin bus cannot stall.
	logic          push_valid;
	logic [FW-1:0] push_word;
	logic [FW-1:0] pop_word;
	logic          pop_valid;
	logic          take;

	always_comb
	begin
		push_valid = cycle_end && sel_s && rst_n_s;
		push_word  = {addr_s[txfdw_pkg::OFS_HI:txfdw_pkg::OFS_LO], wdata};
	end

	txfdw_fifo #(
		.WIDTH (FW),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_word),
		.out_valid (pop_valid),
		.out_ready (take),
		.out_data  (pop_word)
	);

	// Output skid register keeps every output straight from a flop.
	logic                         next_fifo_valid;
	logic [txfdw_pkg::DATA_W-1:0] next_fifo_data;
	logic [OW-1:0]                next_fifo_offset;

	always_comb
	begin
		take             = pop_valid && (!fifo_valid || fifo_ready);
		next_fifo_valid  = fifo_valid && !fifo_ready;
		next_fifo_data   = fifo_data;
		next_fifo_offset = fifo_offset;
		if (take)
		begin
			next_fifo_valid  = 1'b1;
			next_fifo_data   = pop_word[txfdw_pkg::DATA_W-1:0];
			next_fifo_offset = pop_word[FW-1:txfdw_pkg::DATA_W];
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			fifo_valid  <= 1'b0;
			fifo_data   <= '0;
			fifo_offset <= '0;
		end
		else
		begin
			fifo_valid  <= next_fifo_valid;
			fifo_data   <= next_fifo_data;
			fifo_offset <= next_fifo_offset;
		end
	end
endmodule : txfdw_device

// ---- pkg/txfdw_pkg.sv ----
package txfdw_pkg;

	// ==========================================================
	// Bus geometry
	// ==========================================================
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned HALF_W      = 16;
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned OFS_LO      = 1;
	localparam int unsigned OFS_HI      = 2;
	localparam int unsigned CFG_W       = 4;
	localparam int unsigned FIFO_DEPTH  = 32;

	// ==========================================================
	// Timing, in ns (reset width in us) at a 10 ns clock
	// ==========================================================
	localparam int unsigned CLK_NS      = 10;
	localparam int unsigned T_CSL_NS    = 32;
	localparam int unsigned T_CSH_NS    = 13;
	localparam int unsigned T_CYCLE_NS  = 165;
	localparam int unsigned T_CFGSU_NS  = 200;
	localparam int unsigned T_CFGH_NS   = 10;
	localparam int unsigned T_RST_US    = 200;
	localparam int unsigned CSL_CYC     = (T_CSL_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CSH_CYC     = (T_CSH_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYCLE_CYC   = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CFGSU_CYC   = (T_CFGSU_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CFGH_CYC    = (T_CFGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned RST_CYC     = (T_RST_US * 1000 + CLK_NS - 1) / CLK_NS;

	// ==========================================================
	// Host write sequencer states, Gray coded except the HOLD to IDLE step
	// ==========================================================
	typedef enum logic [2:0] {
		TXFDW_IDLE  = 3'b000,
		TXFDW_SETUP = 3'b001,
		TXFDW_LOW   = 3'b011,
		TXFDW_HIGH  = 3'b010,
		TXFDW_RST   = 3'b110,
		TXFDW_HOLD  = 3'b111
	} txfdw_state_t;

endpackage : txfdw_pkg

// ---- pkg/txfdw_if.sv ----
`timescale 1ns/1ps
interface txfdw_if;
	logic                           select_strobe_n;
	logic                           write_strobe_n;
	logic                           hard_reset_n;
	logic                           fifo_sel;
	logic [txfdw_pkg::ADDR_W-1:0]   addr;
	logic [txfdw_pkg::DATA_W-1:0]   data;
	logic [txfdw_pkg::CFG_W-1:0]    cfg;

	modport device (
		input select_strobe_n,
		input write_strobe_n,
		input hard_reset_n,
		input fifo_sel,
		input addr,
		input data,
		input cfg
	);
	modport host (
		output select_strobe_n,
		output write_strobe_n,
		output hard_reset_n,
		output fifo_sel,
		output addr,
		output data,
		output cfg
	);
endinterface : txfdw_if

// ---- hdl/txfdw_fifo.sv ----
`timescale 1ns/1ps
module txfdw_fifo #(
	parameter int unsigned WIDTH = 34,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	always_comb
	begin
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
		if (push)
			mem[wr_ptr] <= in_data;
	end

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
endmodule : txfdw_fifo

// ---- hdl/txfdw_host.sv ----
`timescale 1ns/1ps
module txfdw_host #(
	parameter int unsigned RST_CYC = txfdw_pkg::RST_CYC
) (
	input  wire logic                          clk,
	input  wire logic                          reset,
	txfdw_if.host                              port,
	input  wire logic                          req_valid,
	output logic                               req_ready,
	input  wire logic                          req_fifo,
	input  wire logic [txfdw_pkg::ADDR_W-1:0]  req_addr,
	input  wire logic [txfdw_pkg::DATA_W-1:0]  req_data,
	input  wire logic [txfdw_pkg::CFG_W-1:0]   cfg_value,
	output logic                               busy
);
	localparam int unsigned CW = $clog2(RST_CYC + 1);
	localparam logic [CW-1:0] C_RST  = CW'(RST_CYC - 1);
	localparam logic [CW-1:0] C_SU   = CW'(txfdw_pkg::CFGSU_CYC);
	localparam logic [CW-1:0] C_HOLD = CW'(txfdw_pkg::CFGH_CYC);
	localparam logic [CW-1:0] C_LOW  = CW'(txfdw_pkg::CSL_CYC - 1);
	localparam logic [CW-1:0] C_HIGH = CW'(txfdw_pkg::CYCLE_CYC - txfdw_pkg::CSL_CYC - 2);

	// ==========================================================
	// Write sequencer
	// ==========================================================
	// High time is stretched so one full cycle meets the minimum cycle time.
	txfdw_pkg::txfdw_state_t       state;
	txfdw_pkg::txfdw_state_t       next_state;
	logic [CW-1:0]                 cnt;
	logic [CW-1:0]                 next_cnt;
	logic                          next_cs_n;
	logic                          next_wr_n;
	logic                          next_rst_n;
	logic                          next_sel;
	logic [txfdw_pkg::ADDR_W-1:0]  next_addr;
	logic [txfdw_pkg::DATA_W-1:0]  next_data;
	logic [txfdw_pkg::CFG_W-1:0]   next_cfg;
	logic                          next_req_ready;
	logic                          next_busy;

	always_comb
	begin
		next_state = state;
		next_cnt   = cnt - 1'b1;
		next_cs_n  = port.select_strobe_n;
		next_wr_n  = port.write_strobe_n;
		next_rst_n = port.hard_reset_n;
		next_sel   = port.fifo_sel;
		next_addr  = port.addr;
		next_data  = port.data;
		next_cfg   = port.cfg;
		case (state)
			txfdw_pkg::TXFDW_RST:
			begin
				next_cfg = cfg_value;
				if (cnt <= C_SU)
					next_cfg = port.cfg;
				if (cnt == '0)
				begin
					next_rst_n = 1'b1;
					next_cnt   = C_HOLD;
					next_state = txfdw_pkg::TXFDW_HOLD;
				end
			end
			txfdw_pkg::TXFDW_HOLD:
				if (cnt == '0)
					next_state = txfdw_pkg::TXFDW_IDLE;
			txfdw_pkg::TXFDW_IDLE:
				if (req_valid)
				begin
					next_sel   = req_fifo;
					next_addr  = req_addr;
					next_data  = req_data;
					next_state = txfdw_pkg::TXFDW_SETUP;
				end
			txfdw_pkg::TXFDW_SETUP:
			begin
				next_cs_n  = 1'b0;
				next_wr_n  = 1'b0;
				next_cnt   = C_LOW;
				next_state = txfdw_pkg::TXFDW_LOW;
			end
			txfdw_pkg::TXFDW_LOW:
				if (cnt == '0)
				begin
					next_cs_n  = 1'b1;
					next_wr_n  = 1'b1;
					next_cnt   = C_HIGH;
					next_state = txfdw_pkg::TXFDW_HIGH;
				end
			txfdw_pkg::TXFDW_HIGH:
				if (cnt == '0)
					next_state = txfdw_pkg::TXFDW_IDLE;
			default:
				next_state = txfdw_pkg::TXFDW_IDLE;
		endcase
		if (state == txfdw_pkg::TXFDW_IDLE && !req_valid)
			next_cnt = cnt;
		next_req_ready = (next_state == txfdw_pkg::TXFDW_IDLE) &&
			!(state == txfdw_pkg::TXFDW_IDLE && req_valid);
		next_busy      = next_state != txfdw_pkg::TXFDW_IDLE;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state                <= txfdw_pkg::TXFDW_RST;
			cnt                  <= C_RST;
			port.select_strobe_n <= 1'b1;
			port.write_strobe_n  <= 1'b1;
			port.hard_reset_n    <= 1'b0;
			port.fifo_sel        <= 1'b0;
			port.addr            <= '0;
			port.data            <= '0;
			port.cfg             <= '0;
			req_ready            <= 1'b0;
			busy                 <= 1'b1;
		end
		else
		begin
			state                <= next_state;
			cnt                  <= next_cnt;
			port.select_strobe_n <= next_cs_n;
			port.write_strobe_n  <= next_wr_n;
			port.hard_reset_n    <= next_rst_n;
			port.fifo_sel        <= next_sel;
			port.addr            <= next_addr;
			port.data            <= next_data;
			port.cfg             <= next_cfg;
			req_ready            <= next_req_ready;
			busy                 <= next_busy;
		end
	end
endmodule : txfdw_host

// ---- tb/txfdw_chk.sv ----
`timescale 1ns/1ps
module txfdw_chk #(
	parameter int unsigned RST_CYC = txfdw_pkg::RST_CYC
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        select_strobe_n,
	input wire logic        write_strobe_n,
	input wire logic        hard_reset_n,
	input wire logic        fifo_sel,
	input wire logic [7:0]  addr,
	input wire logic [31:0] data,
	input wire logic [3:0]  cfg
);
	// ======================================
	// Helper counters
	logic        act, act_q, next_act_q;
	logic [7:0]  gap, next_gap, age, next_age;
	logic [15:0] low, next_low;
	logic [3:0]  cfg_q;
	assign act = !select_strobe_n && !write_strobe_n;
	always_comb
	begin
		next_act_q = act;
		next_gap = (act && !act_q) ? 8'h01 : gap + {7'h00, gap != 8'hff};
		next_low = hard_reset_n ? 16'h0000 : low + {15'h0000, low != 16'hffff};
		next_age = (cfg != cfg_q) ? 8'h00 : age + {7'h00, age != 8'hff};
	end
	// Reset is credited with two low cycles, since the pin is held low all through it.
	always_ff @(posedge clk)
	begin
		cfg_q <= cfg;
		if (reset)
		begin
			act_q <= 1'b0;
			gap <= 8'hff;
			low <= 16'h0002;
			age <= 8'h00;
		end
		else
		begin
			act_q <= next_act_q;
			gap <= next_gap;
			low <= next_low;
			age <= next_age;
		end
	end
	// ======================================
	// Wire checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_low_width: assert property (act && !act_q |-> act [*4])
		else $error("strobes low too briefly");
	a_high_width: assert property ($fell(act) |-> !act [*2])
		else $error("strobes high too briefly");
	a_cycle_time: assert property (act && !act_q |-> gap >= 8'h11)
		else $error("write cycle too short");
	a_addr_hold: assert property (act && act_q |-> $stable(addr) && $stable(fifo_sel))
		else $error("address moved in cycle");
	a_data_hold: assert property (act && act_q |-> $stable(data))
		else $error("data moved in cycle");
	a_cfg_window: assert property ($rose(hard_reset_n) |-> age >= 8'h14 ##1 $stable(cfg))
		else $error("config not held around release");
	a_reset_width: assert property ($rose(hard_reset_n) |-> low >= RST_CYC)
		else $error("reset pulse too short");
	a_quiet_reset: assert property (!hard_reset_n |-> !act)
		else $error("write during reset");
	c_fifo: cover property (act && !act_q && fifo_sel);
	c_reg: cover property (act && !act_q && !fifo_sel);
	c_release: cover property ($rose(hard_reset_n));
endmodule : txfdw_chk

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	localparam int unsigned RSTC = 40;
	logic        clk, reset, req_valid, req_ready, req_fifo, bus_16bit, stall, exp_ovf;
	logic        fifo_valid, fifo_ready, reg_write, overflow, busy;
	logic [7:0]  req_addr, reg_addr;
	logic [31:0] req_data, fifo_data, reg_data;
	logic [3:0]  cfg_value, cfg_latched;
	logic [1:0]  fifo_offset;
	logic [33:0] fq[$];
	logic [39:0] rq[$];
	int          err_count, checks_done, seed, i;
	txfdw_if bus();
	txfdw_host #(.RST_CYC(RSTC)) txfdw_host_i (.clk(clk), .reset(reset), .port(bus),
		.req_valid(req_valid), .req_ready(req_ready), .req_fifo(req_fifo), .req_addr(req_addr),
		.req_data(req_data), .cfg_value(cfg_value), .busy(busy));
	txfdw_device txfdw_device_i (.clk(clk), .reset(reset), .port(bus), .bus_16bit(bus_16bit),
		.fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .fifo_data(fifo_data),
		.fifo_offset(fifo_offset), .reg_write(reg_write), .reg_addr(reg_addr),
		.reg_data(reg_data), .cfg_latched(cfg_latched), .overflow(overflow));
	txfdw_chk #(.RST_CYC(RSTC)) txfdw_chk_i (.clk(clk), .reset(reset),
		.select_strobe_n(bus.select_strobe_n), .write_strobe_n(bus.write_strobe_n),
		.hard_reset_n(bus.hard_reset_n), .fifo_sel(bus.fifo_sel), .addr(bus.addr),
		.data(bus.data), .cfg(bus.cfg));
	always #5 clk = ~clk;
	// ======================================
	// Shared tasks
	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic wait_until(input bit drained, input int lim);
		int k;
		k = 0;
		do
		begin
			@(negedge clk);
			k++;
		end
		while ((drained ? (fq.size() + rq.size() != 0) : req_ready !== 1'b1) && k < lim);
		if (k >= lim)
			chk(40'h0, 40'h1, "wait ran out");
	endtask : wait_until
	task automatic send(input logic f, input logic [7:0] a, input logic [31:0] d);
		logic [31:0] e;
		wait_until(1'b0, 200);
		@(posedge clk);
		req_valid <= 1'b1;
		req_fifo <= f;
		req_addr <= a;
		req_data <= d;
		@(posedge clk);
		req_valid <= 1'b0;
		e = bus_16bit ? {16'h0000, d[15:0]} : d;
		if (!f)
			rq.push_back({a, e});
		// The output register holds one word beyond the FIFO's depth.
		else if (fq.size() >= txfdw_pkg::FIFO_DEPTH + 1)
			exp_ovf = 1'b1;
		else
			fq.push_back({a[2:1], e});
	endtask : send
	task automatic do_reset(input logic [3:0] c);
		@(posedge clk);
		reset <= 1'b1;
		cfg_value <= c;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		fq.delete();
		rq.delete();
		exp_ovf = 1'b0;
		wait_until(1'b0, 500);
		repeat (6) @(negedge clk);
		chk(cfg_latched, c, "config");
		chk(busy, 1'b0, "busy after reset");
		chk(overflow, 1'b0, "overflow after reset");
		$display("test reset done");
	endtask : do_reset
	// ======================================
	// Monitor and model comparison
	always @(posedge clk)
	begin
		fifo_ready <= stall ? 1'b0 : 1'($random(seed));
		if (!reset && fifo_valid === 1'b1 && fifo_ready === 1'b1)
			chk({fifo_offset, fifo_data}, fq.size() ? fq.pop_front() : 40'hx, "word");
		if (!reset && reg_write === 1'b1)
			chk({reg_addr, reg_data}, rq.size() ? rq.pop_front() : 40'hx, "reg");
	end
	initial
	begin
		#200000;
		chk(40'h0, 40'h1, "watchdog");
		tally_and_finish();
	end
	// ======================================
	// Test sequence
	initial
	begin
		{clk, reset, req_valid, req_fifo, bus_16bit, fifo_ready, exp_ovf} = 7'h20;
		{req_addr, req_data, cfg_value} = 44'h0;
		{err_count, checks_done, seed, stall} = {32'd0, 32'd0, 32'd41646, 1'b1};
		do_reset(4'ha);
		stall = 1'b0;
		for (i = 0; i < 32; i++)
		begin
			if (i == 20)
			begin
				wait_until(1'b1, 2000);
				@(posedge clk);
				bus_16bit <= 1'b1;
			end
			send(1'($random(seed)), 8'($random(seed)), $random(seed));
		end
		wait_until(1'b1, 2000);
		$display("test mixed done");
		stall = 1'b1;
		@(posedge clk);
		bus_16bit <= 1'b0;
		for (i = 0; i < 34; i++)
			send(1'b1, 8'hf8 | i[2:0], $random(seed));
		repeat (12) @(negedge clk);
		chk(overflow, exp_ovf, "overflow");
		chk(busy, 1'b1, "busy in cycle");
		stall = 1'b0;
		wait_until(1'b1, 2000);
		repeat (4) @(negedge clk);
		chk(fifo_valid, 1'b0, "empty");
		$display("test full done");
		do_reset(4'h3);
		tally_and_finish();
	end
endmodule : tb_top
